// ---- hdl/dsc_pkg.sv ----
package dsc_pkg;
	localparam int DSC_WORD_W = 16;
	localparam int DSC_CELL_W = 17;
	localparam int DSC_OP_W = 5;
	localparam int DSC_STACK_DEPTH = 32;
	localparam int DSC_PTR_W = 5;
	localparam int DSC_TGT_W = 11;

	// Slot counter values and field positions inside the program word
	localparam logic [1:0] DSC_SLOT_FETCH = 2'h0;
	localparam logic [1:0] DSC_SLOT_FIRST = 2'h1;
	localparam logic [1:0] DSC_SLOT_MID = 2'h2;
	localparam logic [1:0] DSC_SLOT_LAST = 2'h3;
	localparam int DSC_F1_LSB = 11;
	localparam int DSC_F2_LSB = 6;
	localparam int DSC_F3_LSB = 1;

	// Values after reset, plus the increment-by-one constants
	localparam logic [DSC_WORD_W-1:0] DSC_RST_WORD = 16'h0000;
	localparam logic [DSC_CELL_W-1:0] DSC_RST_CELL = 17'h00000;
	localparam logic [DSC_PTR_W-1:0] DSC_RST_PTR = 5'h00;
	localparam logic [DSC_WORD_W-1:0] DSC_ONE_WORD = 16'h0001;
	localparam logic [DSC_CELL_W-1:0] DSC_ONE_CELL = 17'h00001;

	// Operation codes, 27 defined out of 32
	localparam logic [4:0] DSC_OP_NOP = 5'h00;
	localparam logic [4:0] DSC_OP_SUBROUTINE_EXIT = 5'h01;
	localparam logic [4:0] DSC_OP_JUMP = 5'h02;
	localparam logic [4:0] DSC_OP_JUMP_ZERO = 5'h03;
	localparam logic [4:0] DSC_OP_JUMP_CARRY = 5'h04;
	localparam logic [4:0] DSC_OP_INVOKE = 5'h05;
	localparam logic [4:0] DSC_OP_LOOP_NEXT = 5'h06;
	localparam logic [4:0] DSC_OP_LOAD_INC = 5'h07;
	localparam logic [4:0] DSC_OP_LOAD = 5'h08;
	localparam logic [4:0] DSC_OP_STORE_INC = 5'h09;
	localparam logic [4:0] DSC_OP_STORE = 5'h0a;
	localparam logic [4:0] DSC_OP_INVERT = 5'h0b;
	localparam logic [4:0] DSC_OP_SHIFT_LEFT = 5'h0c;
	localparam logic [4:0] DSC_OP_SHIFT_RIGHT = 5'h0d;
	localparam logic [4:0] DSC_OP_MUL_STEP = 5'h0e;
	localparam logic [4:0] DSC_OP_DIV_STEP = 5'h0f;
	localparam logic [4:0] DSC_OP_XOR = 5'h10;
	localparam logic [4:0] DSC_OP_AND = 5'h11;
	localparam logic [4:0] DSC_OP_ADD = 5'h12;
	localparam logic [4:0] DSC_OP_TO_PARAMS = 5'h13;
	localparam logic [4:0] DSC_OP_TO_RETURN = 5'h14;
	localparam logic [4:0] DSC_OP_FETCH_PTR = 5'h15;
	localparam logic [4:0] DSC_OP_SET_PTR = 5'h16;
	localparam logic [4:0] DSC_OP_DUP = 5'h17;
	localparam logic [4:0] DSC_OP_DROP = 5'h18;
	localparam logic [4:0] DSC_OP_INT_ENABLE = 5'h19;
	localparam logic [4:0] DSC_OP_INT_DISABLE = 5'h1a;
endpackage : dsc_pkg

// ---- hdl/dsc_stack.sv ----
module dsc_stack
	import dsc_pkg::*;
(
	input wire logic i_core_clk, // Master clock
	input wire logic i_rst, // Synchronous reset
	input wire logic i_push, // Old top moves down, top takes i_top_d
	input wire logic i_pop, // Top takes the entry below
	input wire logic [DSC_CELL_W-1:0] i_top_d, // New top when not popping
	output logic [DSC_CELL_W-1:0] o_top // Top register
);
	logic [DSC_CELL_W-1:0] top_q;
	logic [DSC_PTR_W-1:0] ptr_q;
	logic [DSC_CELL_W-1:0] mem_q [DSC_STACK_DEPTH];
	logic [DSC_PTR_W-1:0] wr_idx;
	logic do_push;
	logic do_pop;

	assign do_push = i_push && !i_pop;
	assign do_pop = i_pop && !i_push;
	// Pointer wraps freely: a 33rd push lands on the oldest entry
	assign wr_idx = ptr_q + DSC_RST_PTR + 5'h01;
	assign o_top = top_q;

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
			top_q <= DSC_RST_CELL;
		else if (do_pop)
			top_q <= mem_q[ptr_q];
		else
			top_q <= i_top_d;
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
			ptr_q <= DSC_RST_PTR;
		else if (do_push)
			ptr_q <= wr_idx;
		else if (do_pop)
			ptr_q <= ptr_q - 5'h01;
	end

	// No reset on the entries; contents above the pointer are don't-care
	for (genvar g = 0; g < DSC_STACK_DEPTH; g++)
	begin : g_entry
		always_ff @(posedge i_core_clk)
		begin
			if (do_push && wr_idx == DSC_PTR_W'(g))
				mem_q[g] <= top_q;
		end
	end
endmodule : dsc_stack

// ---- hdl/dsc_core.sv ----
// Overview of operation
// R1: A 16-bit program word packs up to three 5-bit instructions.
// R2: Decoder implements 27 operations among the 32 possible codes.
// R3: Each instruction finishes in one master clock cycle.
// R4: Registers and stacks change only on the rising clock edge.
// R5: With the clock stopped, all registers and stacks keep their contents.
// R6: Instruction latch and program pointer are 16 bits, 64K words.
// R7: Accumulator, return top, second operand, memory pointer, stacks are 17 bits.
// R8: Accumulator bit 16 is adder carry and moves with the value.
// R9: ALU uses accumulator and second operand, result back to accumulator.
// R10: Accumulator can go to memory pointer, parameter stack or return stack.
// R11: Accumulator links both stacks as one shift register, both directions.
// R12: Memory read loads and write stores accumulator at memory pointer.
// R13: Memory pointer may auto-increment as part of an access.
// R14: Program pointer addresses next word and increments after each fetch.
// R15: Subroutine invoke pushes program pointer onto the return stack.
// R16: Subroutine exit pops the return stack into the program pointer.
// R17: Parameter and return stacks are 32 levels deep each.
// R18: Stacks are circular; overflow and underflow are silent.
// R19: Packed instructions run on successive cycles after the fetch.
// R20: Execution order is high field, middle field, then low field.
// R21: Reset clears slot counter; it then counts 0 to 3 and wraps.
// R22: In the fetch slot the data bus word is latched into the instruction latch.
// R23: Control transfers clear the slot counter so the next cycle fetches.
// R24: Loop-next decrements nonzero return top and branches, else ends loop.
module dsc_core
	import dsc_pkg::*;
(
	input wire logic i_core_clk, // Master clock
	input wire logic i_rst, // Synchronous reset, active high
	input wire logic [DSC_WORD_W-1:0] i_data, // Memory read data
	output logic [DSC_WORD_W-1:0] o_addr, // Memory word address
	output logic [DSC_WORD_W-1:0] o_data, // Memory write data
	output logic o_write, // Write strobe for o_addr
	output logic o_fetch, // Program word fetch cycle
	output logic o_int_enable // Interrupt enable flag
);
	logic [1:0] slot_q;
	logic [1:0] slot_d;
	logic [DSC_WORD_W-1:0] instr_q;
	logic [DSC_WORD_W-1:0] p_q; // [R6]
	logic [DSC_WORD_W-1:0] p_d;
	logic [DSC_CELL_W-1:0] t_q; // [R7]
	logic [DSC_CELL_W-1:0] t_d;
	logic [DSC_CELL_W-1:0] a_q;
	logic [DSC_CELL_W-1:0] a_d;
	logic ie_q;
	logic ie_d;
	logic [DSC_OP_W-1:0] op;
	logic [DSC_CELL_W-1:0] s_top;
	logic [DSC_CELL_W-1:0] r_top;
	logic s_push;
	logic s_pop;
	logic [DSC_CELL_W-1:0] s_d;
	logic r_push;
	logic r_pop;
	logic [DSC_CELL_W-1:0] r_d;
	logic mem_wr;
	logic [DSC_CELL_W-1:0] sum;
	logic [DSC_CELL_W-1:0] mul_sum;
	logic [DSC_CELL_W:0] div_diff;
	logic [DSC_WORD_W-1:0] target;

	// Transfer operations and the no-op end the word early and force a fetch
	function automatic logic is_ctrl(input logic [DSC_OP_W-1:0] code);
		case (code)
			DSC_OP_NOP, DSC_OP_SUBROUTINE_EXIT, DSC_OP_JUMP, DSC_OP_JUMP_ZERO,
			DSC_OP_JUMP_CARRY, DSC_OP_INVOKE, DSC_OP_LOOP_NEXT:
				is_ctrl = 1'b1;
			default:
				is_ctrl = 1'b0;
		endcase
	endfunction : is_ctrl

	// Second operand is the parameter stack top, circular, 32 levels
	dsc_stack u_param_stack ( // [R17] [R18]
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_push(s_push),
		.i_pop(s_pop),
		.i_top_d(s_d),
		.o_top(s_top)
	);

	dsc_stack u_return_stack ( // [R17] [R18]
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_push(r_push),
		.i_pop(r_pop),
		.i_top_d(r_d),
		.o_top(r_top)
	);

	// Field select by slot, high field first
	always_comb
	begin
		case (slot_q)
			DSC_SLOT_FIRST: op = instr_q[DSC_F1_LSB +: DSC_OP_W]; // [R1] [R20]
			DSC_SLOT_MID: op = instr_q[DSC_F2_LSB +: DSC_OP_W]; // [R20]
			DSC_SLOT_LAST: op = instr_q[DSC_F3_LSB +: DSC_OP_W]; // [R20]
			default: op = DSC_OP_NOP;
		endcase
	end

	assign sum = {1'b0, t_q[DSC_WORD_W-1:0]} + {1'b0, s_top[DSC_WORD_W-1:0]}; // [R8]
	assign mul_sum = a_q[0] ? sum : {1'b0, t_q[DSC_WORD_W-1:0]};
	assign div_diff = {1'b0, t_q[DSC_WORD_W-1:0], a_q[DSC_WORD_W-1]}
		- {2'b00, s_top[DSC_WORD_W-1:0]};
	// Branch target keeps the page bits of the pointer
	assign target = {p_q[DSC_WORD_W-1:DSC_TGT_W], instr_q[DSC_TGT_W-1:0]};

	always_comb
	begin
		t_d = t_q;
		a_d = a_q;
		p_d = p_q;
		ie_d = ie_q;
		s_push = 1'b0;
		s_pop = 1'b0;
		s_d = s_top;
		r_push = 1'b0;
		r_pop = 1'b0;
		r_d = r_top;
		mem_wr = 1'b0;
		if (slot_q == DSC_SLOT_FETCH)
			p_d = p_q + DSC_ONE_WORD; // [R14]
		else
		begin
			case (op) // [R2] [R3]
				DSC_OP_SUBROUTINE_EXIT:
				begin
					p_d = r_top[DSC_WORD_W-1:0]; // [R16]
					r_pop = 1'b1;
				end
				DSC_OP_JUMP: p_d = target;
				DSC_OP_JUMP_ZERO:
				begin
					if (t_q[DSC_WORD_W-1:0] == DSC_RST_WORD)
						p_d = target;
				end
				DSC_OP_JUMP_CARRY:
				begin
					if (t_q[DSC_WORD_W])
						p_d = target;
				end
				DSC_OP_INVOKE:
				begin
					r_push = 1'b1; // [R15]
					r_d = {1'b0, p_q};
					p_d = target;
				end
				DSC_OP_LOOP_NEXT:
				begin
					if (r_top != DSC_RST_CELL)
					begin
						r_d = r_top - DSC_ONE_CELL; // [R24]
						p_d = target;
					end
					else
						r_pop = 1'b1; // [R24]
				end
				DSC_OP_LOAD_INC, DSC_OP_LOAD:
				begin
					s_push = 1'b1;
					s_d = t_q;
					t_d = {1'b0, i_data}; // [R12]
					if (op == DSC_OP_LOAD_INC)
						a_d = a_q + DSC_ONE_CELL; // [R13]
				end
				DSC_OP_STORE_INC, DSC_OP_STORE:
				begin
					mem_wr = 1'b1; // [R12]
					t_d = s_top;
					s_pop = 1'b1;
					if (op == DSC_OP_STORE_INC)
						a_d = a_q + DSC_ONE_CELL; // [R13]
				end
				DSC_OP_INVERT: t_d = {t_q[DSC_WORD_W], ~t_q[DSC_WORD_W-1:0]}; // [R9]
				DSC_OP_SHIFT_LEFT: t_d = {t_q[DSC_WORD_W-1:0], 1'b0};
				DSC_OP_SHIFT_RIGHT: t_d = {1'b0, t_q[DSC_CELL_W-1:1]};
				DSC_OP_MUL_STEP:
				begin
					t_d = {1'b0, mul_sum[DSC_CELL_W-1:1]};
					a_d = {1'b0, mul_sum[0], a_q[DSC_WORD_W-1:1]};
				end
				DSC_OP_DIV_STEP:
				begin
					if (!div_diff[DSC_CELL_W])
						t_d = div_diff[DSC_CELL_W-1:0];
					else
						t_d = {t_q[DSC_WORD_W-1:0], a_q[DSC_WORD_W-1]};
					a_d = {1'b0, a_q[DSC_WORD_W-2:0], ~div_diff[DSC_CELL_W]};
				end
				DSC_OP_XOR, DSC_OP_AND, DSC_OP_ADD:
				begin
					s_pop = 1'b1; // [R9]
					if (op == DSC_OP_ADD)
						t_d = sum; // [R8]
					else if (op == DSC_OP_XOR)
						t_d = {t_q[DSC_WORD_W], t_q[DSC_WORD_W-1:0] ^ s_top[DSC_WORD_W-1:0]};
					else
						t_d = {t_q[DSC_WORD_W], t_q[DSC_WORD_W-1:0] & s_top[DSC_WORD_W-1:0]};
				end
				DSC_OP_TO_PARAMS:
				begin
					s_push = 1'b1; // [R11]
					s_d = t_q;
					t_d = r_top;
					r_pop = 1'b1;
				end
				DSC_OP_TO_RETURN:
				begin
					r_push = 1'b1; // [R10] [R11]
					r_d = t_q;
					t_d = s_top;
					s_pop = 1'b1;
				end
				DSC_OP_FETCH_PTR:
				begin
					s_push = 1'b1;
					s_d = t_q;
					t_d = a_q;
				end
				DSC_OP_SET_PTR:
				begin
					a_d = t_q; // [R10]
					t_d = s_top;
					s_pop = 1'b1;
				end
				DSC_OP_DUP:
				begin
					s_push = 1'b1; // [R10]
					s_d = t_q;
				end
				DSC_OP_DROP:
				begin
					t_d = s_top;
					s_pop = 1'b1;
				end
				DSC_OP_INT_ENABLE: ie_d = 1'b1;
				DSC_OP_INT_DISABLE: ie_d = 1'b0;
				default: ;
			endcase
		end
	end

	// Unused codes just move on to the next field; a no-op ends the word and forces a fetch
	always_comb
	begin
		if (slot_q == DSC_SLOT_FETCH)
			slot_d = DSC_SLOT_FIRST; // [R19]
		else if (is_ctrl(op))
			slot_d = DSC_SLOT_FETCH; // [R23]
		else
			slot_d = slot_q + 2'h1; // [R19] [R21]
	end

	// Plain edge flops only; no gating, so a stopped clock holds everything
	always_ff @(posedge i_core_clk) // [R4] [R5]
	begin
		if (i_rst)
			slot_q <= DSC_SLOT_FETCH; // [R21]
		else
			slot_q <= slot_d;
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
			instr_q <= DSC_RST_WORD;
		else if (slot_q == DSC_SLOT_FETCH)
			instr_q <= i_data; // [R22]
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
			p_q <= DSC_RST_WORD;
		else
			p_q <= p_d; // [R14]
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
			t_q <= DSC_RST_CELL;
		else
			t_q <= t_d; // [R9]
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
			a_q <= DSC_RST_CELL;
		else
			a_q <= a_d;
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
			ie_q <= 1'b0;
		else
			ie_q <= ie_d;
	end

	// Single memory port: pointer choice by slot avoids a second bus
	assign o_addr = (slot_q == DSC_SLOT_FETCH) ? p_q : a_q[DSC_WORD_W-1:0]; // [R12]
	assign o_data = t_q[DSC_WORD_W-1:0];
	assign o_write = mem_wr;
	assign o_fetch = (slot_q == DSC_SLOT_FETCH);
	assign o_int_enable = ie_q;

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_rst);

	// Reset itself is the antecedent here, so the default disable must not apply
	reset_slot_a: assert property (disable iff (1'b0) i_rst |=> slot_q == DSC_SLOT_FETCH) // [R21]
		else $error("slot counter not cleared by reset");
	slot_count_a: assert property ((slot_q != DSC_SLOT_FETCH && !is_ctrl(op)) // [R21]
		|=> slot_q == $past(slot_q) + 2'h1)
		else $error("slot counter did not advance");
	// Release edge still samples reset high and leaves the core in the fetch slot
	fetch_latch_a: assert property (!i_rst && slot_q == DSC_SLOT_FETCH // [R22]
		|=> instr_q == $past(i_data) && slot_q == DSC_SLOT_FIRST)
		else $error("program word not latched in fetch slot");
	fetch_inc_a: assert property ((!i_rst && o_fetch) |=> p_q == $past(p_q) + DSC_ONE_WORD) // [R14]
		else $error("program pointer not incremented after fetch");
	ctrl_fetch_a: assert property ((slot_q != DSC_SLOT_FETCH && is_ctrl(op)) // [R23]
		|=> o_fetch)
		else $error("transfer did not force a fetch");
	invoke_push_a: assert property ((!o_fetch && op == DSC_OP_INVOKE) // [R15]
		|=> r_top == {1'b0, $past(p_q)} && p_q == $past(target))
		else $error("invoke did not save the program pointer");
	exit_pop_a: assert property ((!o_fetch && op == DSC_OP_SUBROUTINE_EXIT) // [R16]
		|=> p_q == $past(r_top[DSC_WORD_W-1:0]))
		else $error("exit did not restore the program pointer");
	loop_dec_a: assert property ((!o_fetch && op == DSC_OP_LOOP_NEXT // [R24]
		&& r_top != DSC_RST_CELL) |=> r_top == $past(r_top) - DSC_ONE_CELL
		&& p_q == $past(target))
		else $error("loop-next did not count down and branch");
	add_carry_a: assert property ((!o_fetch && op == DSC_OP_ADD) // [R8]
		|=> t_q == $past(sum) && t_q[DSC_WORD_W] == $past(sum[DSC_WORD_W]))
		else $error("adder carry not kept in accumulator");
	push_shift_a: assert property ((!o_fetch && op == DSC_OP_TO_RETURN) // [R11]
		|=> r_top == $past(t_q) && t_q == $past(s_top))
		else $error("shift toward return stack wrong");
	load_inc_a: assert property ((!o_fetch && op == DSC_OP_LOAD_INC) // [R13]
		|=> a_q == $past(a_q) + DSC_ONE_CELL && t_q == {1'b0, $past(i_data)})
		else $error("load with increment wrong");
	store_port_a: assert property ((o_write // [R12]
		|| (!o_fetch && (op == DSC_OP_STORE || op == DSC_OP_STORE_INC)))
		|-> o_write && !o_fetch && o_addr == a_q[DSC_WORD_W-1:0] && o_data == t_q[DSC_WORD_W-1:0])
		else $error("store not at memory pointer");

	full_word_c: cover property (slot_q == DSC_SLOT_LAST ##1 o_fetch);
	invoke_c: cover property (!o_fetch && op == DSC_OP_INVOKE);
	loop_taken_c: cover property (!o_fetch && op == DSC_OP_LOOP_NEXT && r_top != DSC_RST_CELL);
	div_step_c: cover property (!o_fetch && op == DSC_OP_DIV_STEP);
endmodule : dsc_core

// ---- tb/dsc_mem_model.sv ----
module dsc_mem_model (
	input wire logic i_core_clk, // Master clock
	input wire logic [15:0] i_addr, // Word address
	input wire logic [15:0] i_wdata, // Write data
	input wire logic i_write, // Write strobe
	output logic [15:0] o_rdata // Read data, zero wait states
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [15:0] mem [65536];

	initial
	begin
		for (int k = 0; k < 65536; k++)
			mem[k] = 16'h0000;
	end

	// Combinational answer: the core samples read data in the same cycle
	assign o_rdata = mem[i_addr];

	always @(posedge i_core_clk)
	begin
		if (i_write)
			mem[i_addr] <= i_wdata;
	end
endmodule : dsc_mem_model

// ---- tb/tb_top.sv ----
module tb_top;
	import dsc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	logic i_core_clk = 1'b0;
	logic clk_en = 1'b1;
	logic i_rst = 1'b1;
	logic [15:0] rdata;
	logic [15:0] addr;
	logic [15:0] wdata;
	logic wr;
	logic fetch;
	logic ie;
	int n_fail = 0;
	int samples_checked = 0;
	int cyc = 0;
	logic [15:0] fa[$];
	int fc[$];
	logic fi[$];
	logic [15:0] ef[$];

	// Gate only lets the stop-clock scenario freeze the core
	always #5
		if (clk_en)
			i_core_clk = ~i_core_clk;

	dsc_core u_dsc_core (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_data(rdata),
		.o_addr(addr),
		.o_data(wdata),
		.o_write(wr),
		.o_fetch(fetch),
		.o_int_enable(ie)
	);

	dsc_mem_model u_dsc_mem_model (
		.i_core_clk(i_core_clk),
		.i_addr(addr),
		.i_wdata(wdata),
		.i_write(wr),
		.o_rdata(rdata)
	);

	// Log every fetch: address, cycle since reset release, interrupt flag
	always @(posedge i_core_clk)
	begin
		if (i_rst)
			cyc = 0;
		else
		begin
			if (fetch === 1'b1)
			begin
				fa.push_back(addr);
				fc.push_back(cyc);
				fi.push_back(ie);
			end
			cyc = cyc + 1;
		end
	end

	function automatic logic [15:0] w3(input logic [4:0] a, input logic [4:0] b,
		input logic [4:0] c);
		return {a, b, c, 1'b0};
	endfunction : w3

	function automatic logic [15:0] wj(input logic [4:0] op, input logic [10:0] t);
		return {op, t};
	endfunction : wj

	task automatic put(input int a, input logic [15:0] v);
		u_dsc_mem_model.mem[a] = v;
	endtask : put

	task automatic conclude;
		$display("checks=%0d fails=%0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude

	task automatic chk(input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e)
		begin
			n_fail++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : chk

	// Memory is only touched once the core sits in reset and cannot store
	task automatic hold;
		@(posedge i_core_clk);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_core_clk);
		for (int k = 0; k < 65536; k++)
			u_dsc_mem_model.mem[k] = 16'h0000;
	endtask : hold

	task automatic go;
		repeat (20) @(posedge i_core_clk);
		i_rst <= 1'b0;
		fa.delete();
		fc.delete();
		fi.delete();
	endtask : go

	task automatic waitf(input int n);
		int b;
		b = 0;
		while (fa.size() < n && b < 2000)
		begin
			@(posedge i_core_clk);
			b++;
		end
		if (fa.size() < n)
		begin
			chk(16'(n), 16'(fa.size()));
			conclude();
		end
	endtask : waitf

	task automatic cmpf;
		for (int k = 0; k < ef.size(); k++)
			chk(ef[k], fa[k]);
	endtask : cmpf

	// Jump to word 2, which points the memory pointer at 0x1002
	task automatic pro;
		put(0, wj(DSC_OP_JUMP, 11'h002));
		put(2, w3(DSC_OP_LOAD, DSC_OP_SET_PTR, DSC_OP_NOP));
	endtask : pro

	task automatic t_slots;
		logic [4:0] ie_exp;
		ie_exp = 5'h12;
		hold();
		put(0, w3(DSC_OP_INT_ENABLE, DSC_OP_DUP, DSC_OP_DROP));
		put(1, w3(DSC_OP_INT_DISABLE, 5'h1b, 5'h1f));
		put(2, w3(DSC_OP_INT_ENABLE, 5'h1c, DSC_OP_INT_DISABLE));
		put(3, w3(DSC_OP_INT_DISABLE, 5'h1d, DSC_OP_INT_ENABLE));
		go();
		waitf(5);
		for (int k = 0; k < 5; k++)
		begin
			chk(16'(k), fa[k]);
			chk(16'(4 * k), 16'(fc[k]));
			chk(16'(ie_exp[k]), 16'(fi[k]));
		end
		$display("slots test done");
	endtask : t_slots

	task automatic t_alu;
		hold();
		pro();
		put(16'h1002, 16'hf0f0);
		put(16'h1003, 16'h1010);
		put(3, w3(DSC_OP_LOAD_INC, DSC_OP_LOAD_INC, DSC_OP_ADD));
		put(4, w3(DSC_OP_TO_RETURN, DSC_OP_TO_PARAMS, DSC_OP_DUP));
		put(5, w3(DSC_OP_STORE_INC, DSC_OP_NOP, DSC_OP_NOP));
		put(6, wj(DSC_OP_JUMP_CARRY, 11'h010));
		put(16'h10, w3(DSC_OP_INT_ENABLE, DSC_OP_NOP, DSC_OP_NOP));
		go();
		waitf(8);
		ef = '{16'h0, 16'h2, 16'h3, 16'h4, 16'h5, 16'h6, 16'h10, 16'h11};
		cmpf();
		chk(16'h0100, u_dsc_mem_model.mem[16'h1004]);
		chk(16'h0001, 16'(ie));
		$display("alu test done");
	endtask : t_alu

	task automatic t_call;
		hold();
		put(0, wj(DSC_OP_INVOKE, 11'h030));
		put(16'h30, w3(DSC_OP_SUBROUTINE_EXIT, DSC_OP_INT_ENABLE, DSC_OP_NOP));
		go();
		waitf(4);
		ef = '{16'h0, 16'h30, 16'h1, 16'h2};
		cmpf();
		chk(16'h0002, 16'(fc[1]));
		chk(16'h0006, 16'(fc[3]));
		chk(16'h0000, 16'(ie));
		$display("call test done");
	endtask : t_call

	task automatic t_loop;
		hold();
		pro();
		put(16'h1002, 16'h0002);
		put(3, w3(DSC_OP_LOAD, DSC_OP_TO_RETURN, DSC_OP_NOP));
		put(4, wj(DSC_OP_LOOP_NEXT, 11'h004));
		go();
		waitf(7);
		ef = '{16'h0, 16'h2, 16'h3, 16'h4, 16'h4, 16'h4, 16'h5};
		cmpf();
		$display("loop test done");
	endtask : t_loop

	// Remaining ALU codes, carry through the stack, plain store, zero branch both ways
	task automatic t_ops;
		hold();
		pro();
		put(16'h1002, 16'h00f3);
		put(16'h1003, 16'h0f0f);
		put(16'h1004, 16'h8ff1);
		put(3, w3(DSC_OP_LOAD_INC, DSC_OP_LOAD_INC, DSC_OP_XOR));
		put(4, w3(DSC_OP_LOAD_INC, DSC_OP_AND, DSC_OP_DUP));
		put(5, w3(DSC_OP_STORE_INC, DSC_OP_INVERT, DSC_OP_DUP));
		put(6, w3(DSC_OP_STORE_INC, DSC_OP_SHIFT_LEFT, DSC_OP_DUP));
		put(7, w3(DSC_OP_STORE_INC, DSC_OP_SHIFT_RIGHT, DSC_OP_DUP));
		put(8, w3(DSC_OP_STORE_INC, DSC_OP_FETCH_PTR, DSC_OP_DROP));
		put(9, wj(DSC_OP_JUMP_ZERO, 11'h03f));
		put(10, w3(DSC_OP_STORE, DSC_OP_FETCH_PTR, DSC_OP_STORE_INC));
		put(11, wj(DSC_OP_JUMP_ZERO, 11'h020));
		put(16'h20, w3(DSC_OP_MUL_STEP, DSC_OP_DIV_STEP, DSC_OP_NOP));
		go();
		waitf(13);
		ef = '{16'h0, 16'h2, 16'h3, 16'h4, 16'h5, 16'h6, 16'h7, 16'h8, 16'h9, 16'ha, 16'hb,
			16'h20, 16'h21};
		cmpf();
		chk(16'h0020, 16'(fc[9]));
		chk(16'h002a, 16'(fc[12]));
		chk(16'h0ff0, u_dsc_mem_model.mem[16'h1005]);
		chk(16'hf00f, u_dsc_mem_model.mem[16'h1006]);
		chk(16'he01e, u_dsc_mem_model.mem[16'h1007]);
		chk(16'hf00f, u_dsc_mem_model.mem[16'h1008]);
		chk(16'h1009, u_dsc_mem_model.mem[16'h1009]);
		$display("ops test done");
	endtask : t_ops

	// Forty-two pushes wrap the ring; the stop-clock gap sits mid-program
	task automatic t_stack;
		logic [15:0] e;
		hold();
		pro();
		for (int k = 0; k < 42; k++)
			put(16'h1002 + k, 16'h0100 + 16'(k));
		for (int w = 3; w < 17; w++)
			put(w, w3(DSC_OP_LOAD_INC, DSC_OP_LOAD_INC, DSC_OP_LOAD_INC));
		for (int w = 17; w < 29; w++)
			put(w, w3(DSC_OP_STORE_INC, DSC_OP_STORE_INC, DSC_OP_STORE_INC));
		go();
		waitf(18);
		@(negedge i_core_clk);
		clk_en = 1'b0;
		#302;
		clk_en = 1'b1;
		waitf(29);
		for (int k = 0; k < 36; k++)
		begin
			e = 16'h0100 + 16'((k < 34) ? 41 - k : 73 - k);
			chk(e, u_dsc_mem_model.mem[16'h102c + k]);
		end
		$display("stack test done");
	endtask : t_stack

	initial
	begin
		t_slots();
		t_alu();
		t_call();
		t_loop();
		t_ops();
		t_stack();
		conclude();
	end
endmodule : tb_top
